// >>> rtl/cpc_command_unit.sv
// Command interpreter: settings, status and fault words reached over CAN frames
`timescale 1ns/1ps
`default_nettype none
module cpc_command_unit (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic [7:0] unitAddress,
    input wire logic rxValid,
    input wire cpc_pkg::cpc_frame_s rxFrame,
    output logic txValid,
    output cpc_pkg::cpc_frame_s txFrame,
    input wire logic txReady,
    input wire cpc_pkg::cpc_status_s statusPins,
    input wire logic [cpc_pkg::FAULT_WIDTH-1:0] faultPins,
    input wire logic restartPin,
    output logic acOutputOn,
    output logic chargerInBypassOn,
    output logic solarCharger_n,
    output logic [1:0] operationModeSelect,
    output logic [15:0] chargeCurrentSetpoint,
    output logic [15:0] chargeVoltageSetpoint,
    output logic [15:0] chargeCurveSetup,
    output logic [15:0] outputVoltageActive,
    output logic [15:0] outputFrequencyActive
);
    cpc_pkg::cpc_request_s req;
    cpc_pkg::cpc_status_s statusMeta;
    cpc_pkg::cpc_status_s statusSync;
    logic [cpc_pkg::FAULT_WIDTH-1:0] faultMeta;
    logic [cpc_pkg::FAULT_WIDTH-1:0] faultSync;
    logic restartMeta;
    logic restartSync;
    logic [2:0] outputControl;
    logic settingsUnlocked;
    logic [15:0] outputVoltageSetting;
    logic [15:0] outputFrequencySetting;
    logic writeHit;
    logic readHit;
    logic [15:0] readValue;
    logic readKnown;
    logic [15:0] stateWord;
    logic [15:0] faultWord;

    ////////////////////////////////////////////////////////////////////////////////
    // Frame classification

    cpc_frame_decode u_decode (
        .frame(rxFrame),
        .unitAddress(unitAddress),
        .request(req)
    );

    assign writeHit = rxValid && req.isWrite;
    assign readHit = rxValid && req.isRead;

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; the first stage feeds only the second

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            statusMeta <= '0;
            statusSync <= '0;
            faultMeta <= '0;
            faultSync <= '0;
            restartMeta <= 1'b0;
            restartSync <= 1'b0;
        end else begin
            statusMeta <= statusPins;
            statusSync <= statusMeta;
            faultMeta <= faultPins;
            faultSync <= faultMeta;
            restartMeta <= restartPin;
            restartSync <= restartMeta;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Status and fault words as seen on a read

    // Phase code 01 is unsupported and reads as zero
    assign stateWord = {6'h00,
                        (statusSync.outputPhaseSelect == cpc_pkg::PHASE_UNSUPPORTED) ?
                            cpc_pkg::PHASE_ZERO : statusSync.outputPhaseSelect,
                        1'b0,
                        statusSync.batteryLowAlarm,
                        statusSync.savingActive,
                        statusSync.solarDisable,
                        statusSync.chargerActive,
                        statusSync.mainsPresent,
                        statusSync.outputFromUtility,
                        statusSync.outputFromPowerStage};

    // Low byte overload, protection and storage flags; high byte trips; rest zero
    assign faultWord = {3'h0, faultSync};

    // Read multiplexer; unknown commands get no answer at all
    always_comb begin
        readKnown = 1'b1;
        readValue = 16'h0000;
        unique case (req.cmd)
            cpc_pkg::CMD_CHARGE_CURRENT: readValue = chargeCurrentSetpoint;
            cpc_pkg::CMD_CHARGE_VOLTAGE: readValue = chargeVoltageSetpoint;
            cpc_pkg::CMD_CURVE_SETUP: readValue = chargeCurveSetup;
            cpc_pkg::CMD_SETTINGS_UNLOCK: readValue = 16'h0000;
            cpc_pkg::CMD_OUTPUT_CONTROL: readValue = {13'h0000, outputControl};
            cpc_pkg::CMD_MODE_SETUP: readValue = {14'h0000, operationModeSelect};
            cpc_pkg::CMD_OUTPUT_VOLTAGE: readValue = outputVoltageSetting;
            cpc_pkg::CMD_OUTPUT_FREQUENCY: readValue = outputFrequencySetting;
            cpc_pkg::CMD_STATE_WORD: readValue = stateWord;
            cpc_pkg::CMD_FAULT_WORD: readValue = faultWord;
            default: readKnown = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Charge curve settings, carried as 0.01-scaled integers

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            chargeCurrentSetpoint <= cpc_pkg::CHARGE_CURRENT_RESET;
            chargeVoltageSetpoint <= cpc_pkg::CHARGE_VOLTAGE_RESET;
            chargeCurveSetup <= cpc_pkg::CURVE_SETUP_RESET;
        end else if (writeHit) begin
            if (req.cmd == cpc_pkg::CMD_CHARGE_CURRENT) begin
                chargeCurrentSetpoint <= req.value;
            end
            if (req.cmd == cpc_pkg::CMD_CHARGE_VOLTAGE) begin
                chargeVoltageSetpoint <= req.value;
            end
            if (req.cmd == cpc_pkg::CMD_CURVE_SETUP) begin
                chargeCurveSetup <= req.value;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Output operation control and mode selection

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outputControl <= cpc_pkg::OPC_RESET;
        end else if (writeHit && req.cmd == cpc_pkg::CMD_OUTPUT_CONTROL) begin
            outputControl <= req.value[2:0];
        end
    end

    // Reserved mode codes are refused so the field never holds one
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            operationModeSelect <= cpc_pkg::MODE_SUPPLY;
        end else if (writeHit && req.cmd == cpc_pkg::CMD_MODE_SETUP && !req.value[1]) begin
            operationModeSelect <= req.value[1:0];
        end
    end

    // On/off bit only governs the output once software control is enabled
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            acOutputOn <= 1'b1;
            chargerInBypassOn <= 1'b1;
            solarCharger_n <= 1'b0;
        end else begin
            acOutputOn <= outputControl[cpc_pkg::OPC_ENABLE_BIT] ?
                          outputControl[cpc_pkg::OPC_ON_OFF_BIT] : 1'b1;
            chargerInBypassOn <= outputControl[cpc_pkg::OPC_CHARGER_BIT];
            solarCharger_n <= statusSync.solarDisable;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Protected output voltage and frequency

    // Unlock persists until a wrong password or a restart, so both settings can follow
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            settingsUnlocked <= 1'b0;
        end else if (writeHit && req.cmd == cpc_pkg::CMD_SETTINGS_UNLOCK) begin
            settingsUnlocked <= (req.value == cpc_pkg::UNLOCK_PASSWORD);
        end else if (restartSync) begin
            settingsUnlocked <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outputVoltageSetting <= cpc_pkg::OUTPUT_VOLTAGE_RESET;
            outputFrequencySetting <= cpc_pkg::OUTPUT_FREQUENCY_RESET;
        end else if (writeHit && settingsUnlocked) begin
            if (req.cmd == cpc_pkg::CMD_OUTPUT_VOLTAGE) begin
                outputVoltageSetting <= req.value;
            end
            if (req.cmd == cpc_pkg::CMD_OUTPUT_FREQUENCY) begin
                outputFrequencySetting <= req.value;
            end
        end
    end

    // Stored settings reach the power stage only on a restart
    always_ff @(posedge clock) begin
        if (!rst_n) begin
            outputVoltageActive <= cpc_pkg::OUTPUT_VOLTAGE_RESET;
            outputFrequencyActive <= cpc_pkg::OUTPUT_FREQUENCY_RESET;
        end else if (restartSync) begin
            outputVoltageActive <= outputVoltageSetting;
            outputFrequencyActive <= outputFrequencySetting;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Answer frame; a read arriving while an answer waits is dropped

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            txValid <= 1'b0;
            txFrame <= '0;
        end else if (txValid) begin
            if (txReady) begin
                txValid <= 1'b0;
            end
        end else if (readHit && readKnown) begin
            txValid <= 1'b1;
            txFrame.ext <= 1'b1;
            txFrame.id <= {cpc_pkg::ID_ANSWER_BASE, unitAddress};
            txFrame.len <= cpc_pkg::LEN_ANSWER;
            txFrame.b0 <= req.cmd[7:0];
            txFrame.b1 <= req.cmd[15:8];
            txFrame.b2 <= readValue[7:0];
            txFrame.b3 <= readValue[15:8];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    sequence seqReadTaken;
        readHit && readKnown && !txValid;
    endsequence

    sequence seqAnswerShown;
        txValid && txFrame.id[7:0] == $past(unitAddress) && txFrame.len == cpc_pkg::LEN_ANSWER;
    endsequence

    AST_READ_ANSWER: assert property (seqReadTaken |=> seqAnswerShown)
        else $error("read request not answered");

    AST_ANSWER_HOLD: assert property (txValid && !txReady |=> txValid && $stable(txFrame))
        else $error("answer changed before accepted");

    AST_OUTPUT_GATED: assert property (!outputControl[cpc_pkg::OPC_ENABLE_BIT] |=> acOutputOn)
        else $error("output switched off without control enable");

    AST_OUTPUT_FOLLOWS: assert property ((outputControl[1:0] == 2'h2) [*2] |-> !acOutputOn)
        else $error("enabled off command ignored");

    AST_LOCKED: assert property (!settingsUnlocked |=> $stable(outputVoltageSetting))
        else $error("protected setting changed while locked");

    AST_RESTART_ONLY: assert property (!restartSync |=> $stable(outputVoltageActive))
        else $error("active voltage changed without restart");

    AST_MODE_LEGAL: assert property (!operationModeSelect[1])
        else $error("reserved mode code held");

    AST_PHASE_ZERO: assert property (stateWord[9:8] != cpc_pkg::PHASE_UNSUPPORTED)
        else $error("unsupported phase code visible");

    AST_SOLAR: assert property ($rose(statusPins.solarDisable) ##3 1'b1 |-> solarCharger_n || !$past(statusPins.solarDisable, 2))
        else $error("solar control not following status");

    AST_FOREIGN: assert property (rxValid && rxFrame.id[7:0] != unitAddress |=> $stable(outputControl))
        else $error("frame for other address changed control");

    AST_RESET_CTRL: assert property (disable iff (1'b0) !rst_n |=> outputControl == cpc_pkg::OPC_RESET)
        else $error("control defaults wrong after reset");
endmodule : cpc_command_unit
`default_nettype wire

// >>> rtl/cpc_frame_decode.sv
// Classifies a received frame into a read or write request for this unit
`timescale 1ns/1ps
`default_nettype none
module cpc_frame_decode (
    input wire cpc_pkg::cpc_frame_s frame,
    input wire logic [7:0] unitAddress,
    output cpc_pkg::cpc_request_s request
);
    logic addrMatch;
    logic baseWrite;

    // Only extended frames addressed to us count
    assign addrMatch = frame.ext && (frame.id[7:0] == unitAddress);
    assign baseWrite = frame.id[28:8] == cpc_pkg::ID_WRITE_BASE;
    assign request.isWrite = addrMatch && baseWrite && (frame.len == cpc_pkg::LEN_WRITE);
    assign request.isRead = addrMatch && baseWrite && (frame.len == cpc_pkg::LEN_READ);
    assign request.hit = request.isWrite || request.isRead;
    // Command and value both arrive low byte first
    assign request.cmd = {frame.b1, frame.b0};
    assign request.value = {frame.b3, frame.b2};
endmodule : cpc_frame_decode
`default_nettype wire

// >>> rtl/cpc_pkg.sv
// Constants, frame and status carriers for the CAN power-unit command interpreter
package cpc_pkg;
    // Link figures; bit timing itself lives in the CAN controller
    localparam int LINK_BIT_RATE_BPS = 250000;
    localparam logic [20:0] ID_WRITE_BASE = 21'h000c05;
    localparam logic [20:0] ID_ANSWER_BASE = 21'h000c04;
    localparam logic [3:0] LEN_WRITE = 4'h4;
    localparam logic [3:0] LEN_READ = 4'h2;
    localparam logic [3:0] LEN_ANSWER = 4'h4;
    // Command codes
    localparam logic [15:0] CMD_CHARGE_CURRENT = 16'h00b0;
    localparam logic [15:0] CMD_CHARGE_VOLTAGE = 16'h00b1;
    localparam logic [15:0] CMD_CURVE_SETUP = 16'h00b4;
    localparam logic [15:0] CMD_SETTINGS_UNLOCK = 16'h00cf;
    localparam logic [15:0] CMD_OUTPUT_CONTROL = 16'h0100;
    localparam logic [15:0] CMD_MODE_SETUP = 16'h0101;
    localparam logic [15:0] CMD_OUTPUT_VOLTAGE = 16'h0102;
    localparam logic [15:0] CMD_OUTPUT_FREQUENCY = 16'h0103;
    localparam logic [15:0] CMD_STATE_WORD = 16'h011d;
    localparam logic [15:0] CMD_FAULT_WORD = 16'h011e;
    localparam logic [15:0] UNLOCK_PASSWORD = 16'h574d;
    // Field positions in the output operation control register
    localparam int OPC_ON_OFF_BIT = 0;
    localparam int OPC_ENABLE_BIT = 1;
    localparam int OPC_CHARGER_BIT = 2;
    localparam logic [2:0] OPC_RESET = 3'h5;
    localparam logic [1:0] MODE_SUPPLY = 2'h0;
    localparam logic [1:0] MODE_SAVING = 2'h1;
    localparam logic [1:0] PHASE_ZERO = 2'h0;
    localparam logic [1:0] PHASE_UNSUPPORTED = 2'h1;
    // Reset values of the settings; plain defaults, 0.01 scaling on charge current and voltage, whole units on output voltage and frequency
    localparam logic [15:0] CHARGE_CURRENT_RESET = 16'h1388;
    localparam logic [15:0] CHARGE_VOLTAGE_RESET = 16'h15e0;
    localparam logic [15:0] CURVE_SETUP_RESET = 16'h0000;
    localparam logic [15:0] OUTPUT_VOLTAGE_RESET = 16'h00e6;
    localparam logic [15:0] OUTPUT_FREQUENCY_RESET = 16'h0032;
    localparam int FAULT_WIDTH = 13;

    typedef struct packed {
        logic ext;
        logic [28:0] id;
        logic [3:0] len;
        logic [7:0] b0;
        logic [7:0] b1;
        logic [7:0] b2;
        logic [7:0] b3;
    } cpc_frame_s;

    typedef struct packed {
        logic [1:0] outputPhaseSelect;
        logic batteryLowAlarm;
        logic savingActive;
        logic solarDisable;
        logic chargerActive;
        logic mainsPresent;
        logic outputFromUtility;
        logic outputFromPowerStage;
    } cpc_status_s;

    typedef struct packed {
        logic hit;
        logic isWrite;
        logic isRead;
        logic [15:0] cmd;
        logic [15:0] value;
    } cpc_request_s;
endpackage : cpc_pkg

// >>> verif/cpc_master_model.sv
// Frame-level model of the CAN bus master that addresses the command unit
`timescale 1ns/1ps
`default_nettype none
module cpc_master_model (
    input wire logic clock,
    output logic rxValid,
    output cpc_pkg::cpc_frame_s rxFrame,
    input wire logic txValid,
    input wire cpc_pkg::cpc_frame_s txFrame,
    output logic txReady
);
    ////////////////////////////////////////////////////////////////
    // Cycles the master waits before taking an answer; set by the bench
    int stallCycles = 0;

    // Idle bus at time zero
    initial begin
        rxValid = 1'b0;
        rxFrame = '0;
        txReady = 1'b0;
    end

    // One extended frame, command then value, each low byte first
    task automatic send(input logic [7:0] addr, input logic [3:0] len, input logic [15:0] cmd,
                        input logic [15:0] val);
        @(posedge clock);
        rxValid <= 1'b1;
        rxFrame <= {1'b1, cpc_pkg::ID_WRITE_BASE, addr, len, cmd[7:0], cmd[15:8], val[7:0], val[15:8]};
        @(posedge clock);
        rxValid <= 1'b0;
        rxFrame <= ~rxFrame; // Stale frame must not look valid, so it is inverted
    endtask : send

    // Waits a bounded time for an answer, then stalls before accepting it
    task automatic take(output cpc_pkg::cpc_frame_s f, output logic got);
        got = 1'b0;
        f = '0;
        for (int i = 0; i < 50 && !got; i++) begin
            @(posedge clock);
            got = (txValid === 1'b1);
        end
        if (got) begin
            repeat (stallCycles) @(posedge clock);
            txReady <= 1'b1;
            @(posedge clock);
            f = txFrame;
            txReady <= 1'b0;
        end
    endtask : take
endmodule : cpc_master_model
`default_nettype wire

// >>> verif/tb.sv
// Self-checking bench for the command unit, driven through frame-level reads and writes
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] ADDR = 8'h01;
    logic clock;
    logic rst_n;
    logic rxValid;
    logic txValid;
    logic txReady;
    logic restartPin;
    logic acOutputOn;
    logic chargerInBypassOn;
    logic solarCharger_n;
    logic [1:0] operationModeSelect;
    logic [15:0] chargeCurrentSetpoint;
    logic [15:0] chargeVoltageSetpoint;
    logic [15:0] chargeCurveSetup;
    logic [15:0] outputVoltageActive;
    logic [15:0] outputFrequencyActive;
    logic [cpc_pkg::FAULT_WIDTH-1:0] faultPins;
    cpc_pkg::cpc_frame_s rxFrame;
    cpc_pkg::cpc_frame_s txFrame;
    cpc_pkg::cpc_status_s statusPins;
    int error_cnt = 0;
    int checks_done = 0;
    logic [15:0] rstCmd [7] = '{16'h00b0, 16'h00b1, 16'h00b4, 16'h0100, 16'h0101, 16'h0102, 16'h0103};
    logic [15:0] rstVal [7] = '{16'h1388, 16'h15e0, 16'h0000, 16'h0005, 16'h0000, 16'h00e6, 16'h0032};
    logic [8:0] stPat;
    logic [1:0] ph;

    ////////////////////////////////////////////////////////////////
    // 200 MHz clock
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end

    cpc_command_unit i_dut (.clock(clock), .rst_n(rst_n), .unitAddress(ADDR), .rxValid(rxValid),
        .rxFrame(rxFrame), .txValid(txValid), .txFrame(txFrame), .txReady(txReady), .statusPins(statusPins),
        .faultPins(faultPins), .restartPin(restartPin), .acOutputOn(acOutputOn),
        .chargerInBypassOn(chargerInBypassOn), .solarCharger_n(solarCharger_n),
        .operationModeSelect(operationModeSelect), .chargeCurrentSetpoint(chargeCurrentSetpoint),
        .chargeVoltageSetpoint(chargeVoltageSetpoint), .chargeCurveSetup(chargeCurveSetup),
        .outputVoltageActive(outputVoltageActive), .outputFrequencyActive(outputFrequencyActive));

    cpc_master_model i_master (.clock(clock), .rxValid(rxValid), .rxFrame(rxFrame), .txValid(txValid),
        .txFrame(txFrame), .txReady(txReady));

    ////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Let the given edges land, then sample off the edge
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : settle

    task automatic wr(input logic [7:0] a, input logic [15:0] cmd, input logic [15:0] val);
        i_master.send(a, cpc_pkg::LEN_WRITE, cmd, val);
    endtask : wr

    // Read one command and compare the whole answer frame
    task automatic rd(input logic [15:0] cmd, input logic [15:0] exp);
        cpc_pkg::cpc_frame_s f;
        logic got;
        i_master.send(ADDR, cpc_pkg::LEN_READ, cmd, 16'h0000);
        i_master.take(f, got);
        if (!got) begin
            error_cnt++;
            $display("wrong value answer to %h expected frame seen none", cmd);
            close_out();
        end
        check("answer id", {f.ext, f.id}, {1'b1, cpc_pkg::ID_ANSWER_BASE, ADDR});
        check("answer echo", {f.len, f.b1, f.b0}, {cpc_pkg::LEN_ANSWER, cmd});
        check("answer data", {f.b3, f.b2}, exp);
    endtask : rd

    // Restart level held long enough to pass the synchroniser
    task automatic restart_pulse();
        @(posedge clock);
        restartPin <= 1'b1;
        repeat (5) @(posedge clock);
        restartPin <= 1'b0;
        settle(4);
    endtask : restart_pulse

    // Hang guard
    initial begin
        repeat (100000) @(posedge clock);
        error_cnt++;
        close_out();
    end

    ////////////////////////////////////////////////////////////////
    initial begin
        rst_n = 1'b0;
        restartPin = 1'b0;
        faultPins = '0;
        statusPins = '0;
        repeat (8) @(posedge clock);
        rst_n <= 1'b1;
        settle(1);
        check("ac output", acOutputOn, 1'b1);
        check("charger bypass rst", chargerInBypassOn, 1'b1);
        check("solar drive rst", solarCharger_n, 1'b0);
        check("answer idle rst", txValid, 1'b0);
        check("volt active rst", outputVoltageActive, 16'h00e6);
        check("freq active rst", outputFrequencyActive, 16'h0032);
        foreach (rstCmd[i]) rd(rstCmd[i], rstVal[i]);
        $display("test reset values done");
        // Curve settings in 0.01 units; slow master on the last read
        wr(ADDR, 16'h00b0, 16'h0fa0);
        wr(ADDR, 16'h00b1, 16'h1388);
        wr(ADDR, 16'h00b4, 16'h0040);
        settle(1);
        check("current out", chargeCurrentSetpoint, 16'h0fa0);
        check("voltage out", chargeVoltageSetpoint, 16'h1388);
        check("curve out", chargeCurveSetup, 16'h0040);
        rd(16'h00b0, 16'h0fa0);
        i_master.stallCycles = 4;
        rd(16'h00b1, 16'h1388);
        i_master.stallCycles = 0;
        $display("test charge curve done");
        // Mode codes, reserved ones refused, foreign address ignored
        wr(ADDR, 16'h0101, 16'h0001);
        rd(16'h0101, 16'h0001);
        check("mode out", operationModeSelect, 2'h1);
        wr(ADDR, 16'h0101, 16'h0002);
        wr(ADDR, 16'h0101, 16'h0003);
        rd(16'h0101, 16'h0001);
        wr(ADDR, 16'h0101, 16'h0000);
        wr(8'h02, 16'h0101, 16'h0001);
        rd(16'h0101, 16'h0000);
        i_master.send(8'h02, cpc_pkg::LEN_READ, 16'h0101, 16'h0000);
        settle(3);
        check("foreign answer", txValid, 1'b0);
        $display("test mode and address done");
        // Output control: on/off only counts while enabled
        wr(ADDR, 16'h0100, 16'h0000);
        settle(2);
        check("ac disabled ctl", acOutputOn, 1'b1);
        wr(ADDR, 16'h0100, 16'h0002);
        settle(2);
        check("ac off", acOutputOn, 1'b0);
        check("charger bypass", chargerInBypassOn, 1'b0);
        wr(ADDR, 16'h0100, 16'hfffb);
        settle(2);
        check("ac on", acOutputOn, 1'b1);
        rd(16'h0100, 16'h0003);
        $display("test output control done");
        // Walking one through status inputs, then both phase bits set (phase code 11)
        for (int i = 0; i < 10; i++) begin
            stPat = (i < 9) ? 9'h001 << i : 9'h180;
            @(posedge clock);
            statusPins <= cpc_pkg::cpc_status_s'(stPat);
            settle(4);
            ph = (stPat[8:7] == 2'b01) ? 2'b00 : stPat[8:7];
            check("solar drive", solarCharger_n, stPat[4]);
            rd(16'h011d, {6'h00, ph, 1'b0, stPat[6:0]});
        end
        $display("test status word done");
        // Walking one through the fault inputs
        for (int i = 0; i < cpc_pkg::FAULT_WIDTH; i++) begin
            @(posedge clock);
            faultPins <= 13'h0001 << i;
            settle(3);
            rd(16'h011e, 16'h0001 << i);
        end
        $display("test fault word done");
        // Locked writes are lost; unlocked ones wait for a restart
        wr(ADDR, 16'h0102, 16'h0078);
        restart_pulse();
        check("volt locked", outputVoltageActive, 16'h00e6);
        wr(ADDR, 16'h00cf, 16'h574d);
        wr(ADDR, 16'h0102, 16'h0100);
        wr(ADDR, 16'h0103, 16'h003c);
        settle(5);
        check("volt before restart", outputVoltageActive, 16'h00e6);
        check("freq before restart", outputFrequencyActive, 16'h0032);
        restart_pulse();
        check("volt after restart", outputVoltageActive, 16'h0100);
        check("freq after restart", outputFrequencyActive, 16'h003c);
        wr(ADDR, 16'h00cf, 16'h574c);
        wr(ADDR, 16'h0102, 16'h0078);
        restart_pulse();
        check("volt relocked", outputVoltageActive, 16'h0100);
        $display("test unlock and restart done");
        close_out();
    end
endmodule : tb
`default_nettype wire
